/* hw/tfc_pkg.sv */
package tfc_pkg;
	localparam int FIFO_DEPTH = 8;
	localparam int ENTRY_W    = 16;
	localparam int CNT_W      = 4;

	// Debug control register layout
	localparam int CTL_EN_BIT    = 7;
	localparam int CTL_ARM_BIT   = 6;
	localparam int CTL_TAG_BIT   = 5;
	localparam int CTL_BREAK_ENABLE_BIT = 4;
	localparam logic [7:0] CTL_RESET = 8'hC0;

	// Trigger control register layout
	// Select clear means force-type fetch triggering
	localparam int TRG_SEL_BIT    = 7;
	localparam int TRG_BEGIN_BIT  = 6;
	localparam int TRG_MODE_LSB   = 0;
	localparam int TRG_MODE_W     = 4;
	localparam logic [7:0] TRG_RESET = 8'h40;

	// Comparator A default match on the reset vector fetch
	localparam logic [7:0]  CMPA_EXT_RESET  = 8'h00;
	localparam logic [15:0] CMPA_ADDR_RESET = 16'hFFFE;

	localparam logic [15:0] BRANCH_SRC_OFS = 16'h0002;

	// Trigger mode encodings
	localparam logic [3:0] MODE_A_ONLY      = 4'h0;
	localparam logic [3:0] MODE_A_OR_B      = 4'h1;
	localparam logic [3:0] MODE_A_AND_B     = 4'h2;
	localparam logic [3:0] MODE_EVT_B       = 4'h3;
	localparam logic [3:0] MODE_A_THEN_EVTB = 4'h4;

	typedef struct packed {
		logic        cof_dest;
		logic        cof_branch;
		logic [15:0] addr;
		logic [7:0]  data;
		logic        irq_pending;
		logic        opcode_top;
	} tfc_core_t;

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] trg;
	} tfc_cfg_t;
endpackage

/* hw/tfc_store.sv */
// Eight-deep shift store; oldest entry is index 0
module tfc_store (
	input  wire logic                         sys_clk,
	input  wire logic                         rst,
	input  wire logic                         push,
	input  wire logic [tfc_pkg::ENTRY_W-1:0]  push_data,
	input  wire logic                         pop,
	input  wire logic                         clear,
	output logic      [tfc_pkg::ENTRY_W-1:0]  head,
	output logic                              full
);
	logic [tfc_pkg::ENTRY_W-1:0] mem_r [tfc_pkg::FIFO_DEPTH];
	logic [tfc_pkg::CNT_W-1:0]   fill_r;
	logic [2:0]                  wr_idx;

	assign head = mem_r[0];
	assign full = (fill_r == tfc_pkg::CNT_W'(tfc_pkg::FIFO_DEPTH));

	// Contents survive reset so a host can read out after an end run
	// A push with a pop lands one slot lower, behind the shift
	always_comb begin
		if (full) begin
			wr_idx = 3'(tfc_pkg::FIFO_DEPTH - 1);
		end else if (pop) begin
			wr_idx = fill_r[2:0] - 3'd1;
		end else begin
			wr_idx = fill_r[2:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (pop || (push && full)) begin
			for (int i = 0; i < tfc_pkg::FIFO_DEPTH - 1; i++) begin
				mem_r[i] <= mem_r[i+1];
			end
		end
		if (push) begin
			mem_r[wr_idx] <= push_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || clear) begin
			fill_r <= '0;
		end else if (push && !full && !pop) begin
			fill_r <= fill_r + 1'b1;
		end else if (pop && !push && fill_r != '0) begin
			fill_r <= fill_r - 1'b1;
		end
	end
endmodule

/* hw/tfc_top.sv */
module tfc_top (
	input  wire logic                          sys_clk,
	input  wire logic                          rst,
	input  wire tfc_pkg::tfc_core_t            core,
	input  wire logic                          trigger_hit,
	input  wire logic                          ctl_wr,
	input  wire logic [7:0]                    ctl_wdata,
	input  wire logic                          trg_wr,
	input  wire logic [7:0]                    trg_wdata,
	input  wire logic                          cmpa_wr,
	input  wire logic [23:0]                   cmpa_wdata,
	input  wire logic                          fifo_high_read,
	input  wire logic                          fifo_low_read,
	output tfc_pkg::tfc_cfg_t                  cfg,
	output logic                               armed_flag,
	output logic [7:0]                         comparator_a_ext,
	output logic [15:0]                        comparator_a_addr,
	output logic [tfc_pkg::CNT_W-1:0]          entry_count,
	output logic [7:0]                         fifo_high_data,
	output logic [7:0]                         fifo_low_data,
	output logic                               cpu_break,
	output logic                               reset_request
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_WAIT  = 3'b010,
		ST_STORE = 3'b100
	} tfc_state_t;

	function automatic logic is_event_mode(input logic [3:0] mode);
		is_event_mode = (mode == tfc_pkg::MODE_EVT_B) || (mode == tfc_pkg::MODE_A_THEN_EVTB);
	endfunction

	tfc_state_t                   state_r;
	tfc_state_t                   state_nxt;
	logic [7:0]                   ctl_r;
	logic [7:0]                   trg_r;
	logic                         armed_r;
	logic [15:0]                  prev_addr_r;
	logic [tfc_pkg::CNT_W-1:0]    count_r;
	logic [tfc_pkg::ENTRY_W-1:0]  head;
	logic                         full;
	logic                         push;
	logic [tfc_pkg::ENTRY_W-1:0]  push_data;
	logic                         pop;
	logic                         clear;
	logic                         break_r;
	logic                         end_run_kept;
	logic                         ev_mode;
	logic                         begin_run;
	logic                         trig;
	logic                         cof_any;
	logic [15:0]                  cof_addr;
	logic                         arm_start;
	logic                         done_begin;
	logic                         profile_push;
	logic                         default_rst;

	// Unknown setup at power-up falls to the default branch
	always_comb begin
		default_rst = 1'b0;
		if (rst) begin
			if (end_run_kept) begin
				default_rst = 1'b0;
			end else begin
				default_rst = 1'b1;
			end
		end
	end

	assign ev_mode   = is_event_mode(trg_r[tfc_pkg::TRG_MODE_LSB +: tfc_pkg::TRG_MODE_W]);
	// Event modes always count as begin runs
	assign begin_run = trg_r[tfc_pkg::TRG_BEGIN_BIT] || ev_mode;
	assign cof_any   = core.cof_dest || core.cof_branch;
	assign end_run_kept = ctl_r[tfc_pkg::CTL_EN_BIT] && !trg_r[tfc_pkg::TRG_BEGIN_BIT];

	// Opcode triggering loses the race to a pending interrupt
	assign trig = trigger_hit &&
		!(trg_r[tfc_pkg::TRG_SEL_BIT] && core.irq_pending && core.opcode_top);

	// Destination flow has priority over branch source
	always_comb begin
		if (core.cof_dest) begin
			cof_addr = core.addr;
		end else begin
			cof_addr = prev_addr_r - tfc_pkg::BRANCH_SRC_OFS;
		end
	end

	always_ff @(posedge sys_clk) begin
		prev_addr_r <= core.addr;
	end

	assign arm_start = ctl_wr && ctl_wdata[tfc_pkg::CTL_EN_BIT] && ctl_wdata[tfc_pkg::CTL_ARM_BIT]
		&& !(ctl_r[tfc_pkg::CTL_ARM_BIT] && armed_r);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (arm_start) begin
					state_nxt = trg_wr ? (trg_wdata[tfc_pkg::TRG_BEGIN_BIT] ? ST_WAIT : ST_STORE)
						: (begin_run ? ST_WAIT : ST_STORE);
				end
			end
			ST_WAIT: begin
				if (trig) begin
					state_nxt = ST_STORE;
				end
			end
			ST_STORE: begin
				if (!begin_run && trig) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (!armed_r && state_r != ST_IDLE) begin
			state_nxt = ST_IDLE;
		end
	end

	// Begin run stores the triggering flow too, including interrupt flow
	assign done_begin = begin_run && armed_r && push && (count_r == tfc_pkg::CNT_W'(tfc_pkg::FIFO_DEPTH - 1));

	always_comb begin
		push      = 1'b0;
		push_data = cof_addr;
		if (armed_r && ev_mode) begin
			push_data = {8'h00, core.data};
			push      = (state_r == ST_STORE || (state_r == ST_WAIT && trig)) && trigger_hit;
		end else if (armed_r && cof_any) begin
			case (state_r)
				ST_WAIT: begin
					push = trig;
				end
				ST_STORE: begin
					// Fetch end trigger skips the interrupt's flow; opcode end keeps it
					push = !(trig && !begin_run && core.irq_pending && !trg_r[tfc_pkg::TRG_SEL_BIT]);
				end
				default: begin
					push = 1'b0;
				end
			endcase
		end
		if (profile_push) begin
			push      = 1'b1;
			push_data = core.addr;
		end
		if (begin_run && count_r == tfc_pkg::CNT_W'(tfc_pkg::FIFO_DEPTH) && armed_r) begin
			push = 1'b0;
		end
	end

	// Profile sample lands in the store slot just freed by the read
	assign profile_push = fifo_low_read && !armed_r && !ctl_r[tfc_pkg::CTL_ARM_BIT];
	assign pop   = fifo_low_read && !armed_r;
	assign clear = arm_start;

	tfc_store u_store (
		.sys_clk   (sys_clk),
		.rst       (default_rst),
		.push      (push),
		.push_data (push_data),
		.pop       (pop),
		.clear     (clear),
		.head      (head),
		.full      (full)
	);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			if (end_run_kept) begin
				state_r <= ST_IDLE;
			end else begin
				state_r <= ST_WAIT;
			end
		end else begin
			state_r <= state_nxt;
		end
	end

	// Control register with its two reset behaviours
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			if (end_run_kept) begin
				ctl_r[tfc_pkg::CTL_ARM_BIT]   <= 1'b0;
				ctl_r[tfc_pkg::CTL_BREAK_ENABLE_BIT] <= 1'b0;
			end else begin
				ctl_r <= tfc_pkg::CTL_RESET;
			end
		end else if (ctl_wr) begin
			ctl_r <= ctl_wdata;
		end else if ((state_r == ST_STORE && !begin_run && trig) || done_begin) begin
			ctl_r[tfc_pkg::CTL_ARM_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			if (end_run_kept) begin
				trg_r <= trg_r;
			end else begin
				trg_r <= tfc_pkg::TRG_RESET;
			end
		end else if (trg_wr) begin
			trg_r <= trg_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			if (end_run_kept) begin
				comparator_a_ext  <= comparator_a_ext;
			end else begin
				comparator_a_ext  <= tfc_pkg::CMPA_EXT_RESET;
				comparator_a_addr <= tfc_pkg::CMPA_ADDR_RESET;
			end
		end else if (cmpa_wr) begin
			comparator_a_ext  <= cmpa_wdata[23:16];
			comparator_a_addr <= cmpa_wdata[15:0];
		end
	end

	// Armed flag follows arm and enable; end run reset drops it, default reset sets it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			if (end_run_kept) begin
				armed_r <= 1'b0;
			end else begin
				armed_r <= 1'b1;
			end
		end else if (arm_start) begin
			armed_r <= 1'b1;
		end else if (!ctl_r[tfc_pkg::CTL_EN_BIT] || !ctl_r[tfc_pkg::CTL_ARM_BIT]) begin
			armed_r <= 1'b0;
		end else if ((state_r == ST_STORE && !begin_run && trig) || done_begin) begin
			armed_r <= 1'b0;
		end
	end

	// Count saturates and is not touched by readout
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			if (end_run_kept) begin
				count_r <= count_r;
			end else begin
				count_r <= '0;
			end
		end else if (arm_start) begin
			count_r <= '0;
		end else if (armed_r && push && count_r != tfc_pkg::CNT_W'(tfc_pkg::FIFO_DEPTH)) begin
			count_r <= count_r + 1'b1;
		end
	end

	// Break on full in begin runs; cleared by reset or a control write, except one in the same cycle as the fill
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			break_r <= 1'b0;
		end else if (done_begin && ctl_r[tfc_pkg::CTL_BREAK_ENABLE_BIT]) begin
			break_r <= 1'b1;
		end else if (ctl_wr) begin
			break_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		fifo_high_data <= ev_mode ? 8'h00 : head[15:8];
		fifo_low_data  <= head[7:0];
	end

	assign cfg.ctl       = ctl_r;
	assign cfg.trg       = trg_r;
	assign armed_flag    = armed_r;
	assign entry_count   = count_r;
	assign cpu_break     = break_r;
	assign reset_request = 1'b0;
endmodule

/* verif/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic               sys_clk, rst, trigger_hit, ctl_wr, trg_wr, cmpa_wr, fifo_high_read, fifo_low_read;
	logic               armed_flag, cpu_break, reset_request;
	logic [7:0]         ctl_wdata, trg_wdata, cax, fhi, flo;
	logic [23:0]        cmpa_wdata;
	logic [15:0]        caa, v, samp, s0;
	logic [3:0]         entry_count;
	tfc_pkg::tfc_core_t core;
	tfc_pkg::tfc_cfg_t  cfg;
	int                 bad_count, num_checks;
	tfc_core_model cm (.sys_clk, .core, .trig(trigger_hit));
	tfc_top dut_u (.sys_clk, .rst, .core, .trigger_hit, .ctl_wr, .ctl_wdata, .trg_wr, .trg_wdata, .cmpa_wr,
		.cmpa_wdata, .fifo_high_read, .fifo_low_read, .cfg, .armed_flag, .comparator_a_ext(cax),
		.comparator_a_addr(caa), .entry_count, .fifo_high_data(fhi), .fifo_low_data(flo), .cpu_break,
		.reset_request);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_sim;
		if (bad_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(int w, logic [23:0] d);
		@(negedge sys_clk);
		ctl_wr <= w == 0;
		trg_wr <= w == 1;
		cmpa_wr <= w == 2;
		ctl_wdata <= d[7:0];
		trg_wdata <= d[7:0];
		cmpa_wdata <= d;
		@(negedge sys_clk);
		{ctl_wr, trg_wr, cmpa_wr} <= 3'b000;
	endtask
	// Data follows a pop by one cycle, so each read waits three
	task automatic rd(output logic [15:0] d);
		@(negedge sys_clk);
		d = {fhi, flo};
		fifo_high_read <= 1'b1;
		@(negedge sys_clk);
		fifo_high_read <= 1'b0;
		fifo_low_read <= 1'b1;
		@(posedge sys_clk);
		samp = core.addr;
		@(negedge sys_clk);
		fifo_low_read <= 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic do_reset;
		@(negedge sys_clk);
		rst <= 1'b1;
		repeat (16) @(negedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic go(logic d, logic b, logic [15:0] a, logic [7:0] dt, logic [1:0] ip, logic t);
		cm.step({d, b, a, dt, ip}, t);
	endtask
	task automatic chk_def;
		chk("ctl", 16'h00C0, {8'h00, cfg.ctl});
		chk("trg", 16'h0040, {8'h00, cfg.trg});
		chk("cmpa", 16'h00FE, {cax, caa[7:0]});
		chk("cmpa hi", 16'h00FF, {8'h00, caa[15:8]});
		chk("armed", 16'h0001, {15'h0000, armed_flag});
		chk("rst req", 16'h0000, {15'h0000, reset_request});
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		end_sim;
	end
	initial begin
		rst = 1'b1;
		{ctl_wr, trg_wr, cmpa_wr, fifo_high_read, fifo_low_read} = 5'h00;
		{ctl_wdata, trg_wdata, cmpa_wdata} = 40'h0000000000;
		bad_count = 0;
		num_checks = 0;
		do_reset;
		chk_def;
		wr(2, 24'h123456);
		wr(0, 24'h000000);
		wr(1, 24'h000000);
		wr(0, 24'h0000D0);
		for (int i = 0; i < 10; i++)
			go(1'b1, 1'b0, 16'h1000 + i[15:0], 8'h00, 2'b00, 1'b0);
		rd(v);
		rd(v);
		chk("armed read", 16'h1002, v);
		chk("count", 16'h0008, {12'h000, entry_count});
		go(1'b1, 1'b0, 16'h2000, 8'h00, 2'b00, 1'b1);
		@(negedge sys_clk);
		chk("end armed", 16'h0000, {15'h0000, armed_flag});
		chk("end ctl", 16'h0090, {8'h00, cfg.ctl});
		do_reset;
		chk("kept ctl", 16'h0080, {8'h00, cfg.ctl});
		chk("kept cmpa", 16'h3456, caa);
		chk("kept count", 16'h0008, {12'h000, entry_count});
		for (int i = 0; i < 8; i++) begin
			rd(v);
			if (i == 0)
				s0 = samp;
			chk("end fifo", i < 7 ? 16'h1003 + i[15:0] : 16'h2000, v);
		end
		rd(v);
		chk("profile", s0, v);
		chk("read count", 16'h0008, {12'h000, entry_count});
		wr(0, 24'h000000);
		do_reset;
		chk_def;
		wr(0, 24'h000000);
		wr(1, 24'h0000C0);
		wr(0, 24'h0000D0);
		go(1'b1, 1'b0, 16'h3333, 8'h00, 2'b00, 1'b0);
		go(1'b1, 1'b0, 16'h4444, 8'h00, 2'b11, 1'b1);
		go(1'b1, 1'b0, 16'h5555, 8'h00, 2'b00, 1'b0);
		@(negedge sys_clk);
		chk("idle count", 16'h0000, {12'h000, entry_count});
		go(1'b0, 1'b0, 16'h0000, 8'h00, 2'b00, 1'b1);
		go(1'b0, 1'b0, 16'h3000, 8'h00, 2'b00, 1'b0);
		go(1'b0, 1'b1, 16'h3100, 8'h00, 2'b00, 1'b0);
		for (int i = 0; i < 8; i++)
			go(1'b1, 1'b0, 16'h6000 + i[15:0], 8'h00, 2'b00, 1'b0);
		@(negedge sys_clk);
		chk("full count", 16'h0008, {12'h000, entry_count});
		chk("full armed", 16'h0000, {15'h0000, armed_flag});
		chk("break", 16'h0001, {15'h0000, cpu_break});
		for (int i = 0; i < 8; i++) begin
			rd(v);
			chk("begin fifo", i == 0 ? 16'h2FFE : 16'h5FFF + i[15:0], v);
		end
		wr(1, 24'h000043);
		wr(0, 24'h0000C0);
		go(1'b1, 1'b0, 16'hBEEF, 8'hA5, 2'b00, 1'b1);
		go(1'b0, 1'b0, 16'h1234, 8'h3C, 2'b00, 1'b1);
		wr(0, 24'h000080);
		@(negedge sys_clk);
		chk("evt count", 16'h0002, {12'h000, entry_count});
		rd(v);
		chk("evt 0", 16'h00A5, v);
		rd(v);
		chk("evt 1", 16'h003C, v);
		end_sim;
	end
endmodule

/* verif/tfc_core_model.sv */
module tfc_core_model (
	input  wire logic         sys_clk,
	output tfc_pkg::tfc_core_t core,
	output logic              trig
);
	timeunit 1ns;
	timeprecision 1ns;
	tfc_pkg::tfc_core_t req;
	logic               req_trig, pend;
	initial begin
		core = '0;
		trig = 1'b0;
		pend = 1'b0;
	end
	// Idle address and data toggle so a stale value never passes for a fresh one
	always @(negedge sys_clk) begin
		if (pend) begin
			core <= req;
			trig <= req_trig;
			pend <= 1'b0;
		end else begin
			core <= {2'b00, ~core.addr, ~core.data, 2'b00};
			trig <= 1'b0;
		end
	end
	// The 1 ns step keeps the hand-off clear of the falling edge
	task automatic step(input tfc_pkg::tfc_core_t c, input logic t);
		#1;
		req = c;
		req_trig = t;
		pend = 1'b1;
		do @(posedge sys_clk); while (pend);
	endtask
endmodule

/* verif/tfc_properties.sv */
module tfc_properties (
	input wire logic                      sys_clk,
	input wire logic                      rst,
	input wire tfc_pkg::tfc_core_t        core,
	input wire logic                      trigger_hit,
	input wire logic                      ctl_wr,
	input wire logic                      fifo_low_read,
	input wire tfc_pkg::tfc_cfg_t         cfg,
	input wire logic                      armed_flag,
	input wire logic [7:0]                comparator_a_ext,
	input wire logic [15:0]               comparator_a_addr,
	input wire logic [tfc_pkg::CNT_W-1:0] entry_count,
	input wire logic                      cpu_break,
	input wire logic                      reset_request
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic       evt, begin_run, end_hit, in_rst_r, keep_end_r;
	logic [7:0] keep_ctl_r;
	assign evt = cfg.trg[3:0] == tfc_pkg::MODE_EVT_B || cfg.trg[3:0] == tfc_pkg::MODE_A_THEN_EVTB;
	assign begin_run = cfg.trg[tfc_pkg::TRG_BEGIN_BIT] || evt;
	// Opcode trigger swallowed by a pending interrupt is no hit
	assign end_hit = armed_flag && !begin_run && trigger_hit && !ctl_wr
		&& !(cfg.trg[tfc_pkg::TRG_SEL_BIT] && core.irq_pending && core.opcode_top);
	// Reset flavour is fixed by the setup seen at reset onset
	always_ff @(posedge sys_clk) begin
		in_rst_r <= rst;
		if (rst && !in_rst_r) begin
			keep_end_r <= cfg.ctl[7] && !cfg.trg[tfc_pkg::TRG_BEGIN_BIT];
			keep_ctl_r <= cfg.ctl;
		end
	end
	a_no_reset_req: assert property (reset_request == 1'b0) else $error("reset request raised");
	a_count_limit: assert property (entry_count <= 4'h8) else $error("count above eight");
	a_count_readout: assert property (!armed_flag && !ctl_wr |=> $stable(entry_count))
		else $error("count moved while disarmed");
	a_end_disarm: assert property (end_hit |=> !armed_flag && !cfg.ctl[6]) else $error("end trigger kept arm");
	a_end_store: assert property (end_hit && core.cof_dest && !core.irq_pending && entry_count < 4'h8
		|=> entry_count == $past(entry_count) + 4'h1) else $error("trigger flow not stored");
	a_irq_end_skip: assert property (end_hit && !cfg.trg[tfc_pkg::TRG_SEL_BIT] && core.irq_pending
		&& entry_count < 4'h8
		|=> $stable(entry_count)) else $error("interrupt flow stored at end");
	a_irq_begin_keep: assert property (armed_flag && cfg.trg[tfc_pkg::TRG_BEGIN_BIT] && !evt
		&& !cfg.trg[tfc_pkg::TRG_SEL_BIT] && trigger_hit
		&& core.irq_pending && core.cof_dest && !ctl_wr && entry_count < 4'h7
		|=> armed_flag && entry_count == $past(entry_count) + 4'h1) else $error("interrupt flow lost");
	a_begin_full_stop: assert property ($rose(entry_count == 4'h8) && begin_run |-> ##[0:1] !armed_flag)
		else $error("armed after fill");
	a_full_break: assert property ($rose(entry_count == 4'h8) && begin_run && cfg.ctl[4]
		|-> ##[0:1] cpu_break) else $error("no break on fill");
	a_armed_read_block: assert property (armed_flag && fifo_low_read && !ctl_wr
		|=> entry_count == $past(entry_count)) else $error("armed read let store through");
	a_end_reset_keep: assert property ($fell(rst) && keep_end_r
		|-> cfg.ctl == (keep_ctl_r & 8'hAF) && !armed_flag) else $error("end run reset lost setup");
	a_default_reset: assert property ($fell(rst) && !keep_end_r |-> cfg.ctl == 8'hC0 && cfg.trg == 8'h40
		&& comparator_a_ext == 8'h00 && comparator_a_addr == 16'hFFFE && armed_flag) else $error("bad defaults");
	c_end_hit: cover property (end_hit);
	c_begin_full: cover property ($rose(entry_count == 4'h8) && begin_run);
	c_armed_read: cover property (armed_flag && fifo_low_read);
endmodule

bind tfc_top tfc_properties chk_u (.sys_clk, .rst, .core, .trigger_hit, .ctl_wr, .fifo_low_read, .cfg, .armed_flag,
	.comparator_a_ext, .comparator_a_addr, .entry_count, .cpu_break, .reset_request);
